// [rtl/gdc_consts.vh]
// Constants for the gate driver configuration register bank
`ifndef GDC_CONSTS_VH
`define GDC_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define GDC_ADDR_W 6
`define GDC_ADDR_LOCKCTL 6'h02
`define GDC_ADDR_GDWD 6'h03
`define GDC_ADDR_OCMON 6'h04
`define GDC_ADDR_REGCFG 6'h05

// ****************************************
// Reset values
// ****************************************
`define GDC_RST_GDWD 8'h07
`define GDC_RST_OCMON 8'h70
`define GDC_RST_REGCFG 8'h01

// ****************************************
// Field positions
// ****************************************
`define GDC_DEAD_HI 7
`define GDC_DEAD_LO 6
`define GDC_WDEN_BIT 5
`define GDC_WDTO_HI 4
`define GDC_WDTO_LO 3
`define GDC_IDRV_HI 2
`define GDC_IDRV_LO 0
`define GDC_CLAMP_BIT 7
`define GDC_VDS_HI 6
`define GDC_VDS_LO 4
`define GDC_MOFF_HI 3
`define GDC_MOFF_LO 0
`define GDC_CHOP_OFFTIME_SEL_HI 7
`define GDC_CHOP_OFFTIME_SEL_LO 6
`define GDC_RDIS_BIT 5
`define GDC_SCL_HI 4
`define GDC_SCL_LO 3
`define GDC_SH_BIT 2
`define GDC_GAIN_HI 1
`define GDC_GAIN_LO 0
`define GDC_LOCK_HI 5
`define GDC_LOCK_LO 3

// ****************************************
// Lock codes
// ****************************************
`define GDC_LOCK_CODE 3'h6
`define GDC_UNLOCK_CODE 3'h3

// ****************************************
// Watchdog timing, ms, at a 10 MHz clock
// ****************************************
`define GDC_CLK_KHZ 10000
`define GDC_WD_MS0 10
`define GDC_WD_MS1 20
`define GDC_WD_MS2 50
`define GDC_WD_MS3 100
`define GDC_WD_CNT_W 20

`endif

// [rtl/gdc_config_regs.v]
// Gate driver configuration registers with lock and watchdog

`include "gdc_consts.vh"

// Contract
// - Two-bit dead time code, reset zero
// - Watchdog runs only when enable bit set
// - Timeout code picks 10/20/50/100 ms
// - Three-bit gate current strength, reset 111b
// - Output clamp bit, reset clear
// - Three-bit overcurrent threshold, reset 111b
// - Four per-FET monitor disables, reset enabled
// - Two-bit chop off time, reset zero
// - Regulation disable bit, reset zero
// - Two-bit reference scale, reset zero
// - Sample-hold enable bit, reset zero
// - Two-bit amplifier gain, reset 01b
// - Lock code 110b blocks writes; 011b unlocks
module gdc_config_regs #(
  parameter WD_SCALE_KHZ = `GDC_CLK_KHZ
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Register port from the serial interface
  input wire reg_wr,
  input wire reg_rd,
  input wire [`GDC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Fault handling
  input wire fault_clear,
  output reg watchdog_fault,
  output reg config_locked,
  // Dead time and gate drive
  output wire [1:0] bridge_deadtime_sel,
  output wire watchdog_enable_bit,
  output wire [1:0] watchdog_timeout_sel,
  output wire [2:0] gate_current_strength,
  // Overcurrent monitor
  output wire sense_output_clamp,
  output wire [2:0] drain_source_threshold,
  output wire high2_monitor_off,
  output wire low2_monitor_off,
  output wire high1_monitor_off,
  output wire low1_monitor_off,
  // Current regulation
  output wire [1:0] chop_offtime_sel,
  output wire regulation_disable,
  output wire [1:0] reference_scale_sel,
  output wire sample_hold_enable,
  output wire [1:0] amp_gain_sel
);

  // ****************************************
  // Timeout table
  // ****************************************
  // Products are formed at full width, then cut to the counter on purpose
  localparam [31:0] WD_RAW0 = `GDC_WD_MS0 * WD_SCALE_KHZ;
  localparam [31:0] WD_RAW1 = `GDC_WD_MS1 * WD_SCALE_KHZ;
  localparam [31:0] WD_RAW2 = `GDC_WD_MS2 * WD_SCALE_KHZ;
  localparam [31:0] WD_RAW3 = `GDC_WD_MS3 * WD_SCALE_KHZ;
  localparam [`GDC_WD_CNT_W-1:0] WD_CYC0 = WD_RAW0[`GDC_WD_CNT_W-1:0];
  localparam [`GDC_WD_CNT_W-1:0] WD_CYC1 = WD_RAW1[`GDC_WD_CNT_W-1:0];
  localparam [`GDC_WD_CNT_W-1:0] WD_CYC2 = WD_RAW2[`GDC_WD_CNT_W-1:0];
  localparam [`GDC_WD_CNT_W-1:0] WD_CYC3 = WD_RAW3[`GDC_WD_CNT_W-1:0];

  function [`GDC_WD_CNT_W-1:0] wd_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wd_limit = WD_CYC0;
        2'h1: wd_limit = WD_CYC1;
        2'h2: wd_limit = WD_CYC2;
        default: wd_limit = WD_CYC3;
      endcase
    end
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  reg [7:0] gate_drive_watchdog_ctrl;
  reg [7:0] overcurrent_monitor_ctrl;
  reg [7:0] current_regulation_cfg;
  reg [2:0] lock_field;
  wire cfg_wr_ok;
  wire wr_gdwd;
  wire wr_ocmon;
  wire wr_regcfg;
  wire wr_lockctl;

  // ****************************************
  // Write decode
  // ****************************************
  // Writes to the lock register itself are always taken
  assign cfg_wr_ok = reg_wr && !config_locked;
  assign wr_gdwd = cfg_wr_ok && (reg_addr == `GDC_ADDR_GDWD);
  assign wr_ocmon = cfg_wr_ok && (reg_addr == `GDC_ADDR_OCMON);
  assign wr_regcfg = cfg_wr_ok && (reg_addr == `GDC_ADDR_REGCFG);
  assign wr_lockctl = reg_wr && (reg_addr == `GDC_ADDR_LOCKCTL);

  // One process per register keeps each reset value next to its fields
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_drive_watchdog_ctrl <= `GDC_RST_GDWD;
    end else if (wr_gdwd) begin
      gate_drive_watchdog_ctrl <= reg_wdata;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overcurrent_monitor_ctrl <= `GDC_RST_OCMON;
    end else if (wr_ocmon) begin
      overcurrent_monitor_ctrl <= reg_wdata;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      current_regulation_cfg <= `GDC_RST_REGCFG;
    end else if (wr_regcfg) begin
      current_regulation_cfg <= reg_wdata;
    end
  end

  // ****************************************
  // Lock state
  // ****************************************
  wire [2:0] lock_wcode = reg_wdata[`GDC_LOCK_HI:`GDC_LOCK_LO];

  // Only the matching code changes state; other values leave it alone
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      config_locked <= 1'b0;
      lock_field <= `GDC_UNLOCK_CODE;
    end else if (wr_lockctl) begin
      if (!config_locked && lock_wcode == `GDC_LOCK_CODE) begin
        config_locked <= 1'b1;
        lock_field <= `GDC_LOCK_CODE;
      end else if (config_locked && lock_wcode == `GDC_UNLOCK_CODE) begin
        config_locked <= 1'b0;
        lock_field <= `GDC_UNLOCK_CODE;
      end
    end
  end

  // ****************************************
  // Field outputs
  // ****************************************
  assign bridge_deadtime_sel = gate_drive_watchdog_ctrl[`GDC_DEAD_HI:`GDC_DEAD_LO];
  assign watchdog_enable_bit = gate_drive_watchdog_ctrl[`GDC_WDEN_BIT];
  assign watchdog_timeout_sel = gate_drive_watchdog_ctrl[`GDC_WDTO_HI:`GDC_WDTO_LO];
  assign gate_current_strength = gate_drive_watchdog_ctrl[`GDC_IDRV_HI:`GDC_IDRV_LO];
  assign sense_output_clamp = overcurrent_monitor_ctrl[`GDC_CLAMP_BIT];
  assign drain_source_threshold = overcurrent_monitor_ctrl[`GDC_VDS_HI:`GDC_VDS_LO];
  assign {high2_monitor_off, low2_monitor_off, high1_monitor_off, low1_monitor_off} =
    overcurrent_monitor_ctrl[`GDC_MOFF_HI:`GDC_MOFF_LO];
  assign chop_offtime_sel = current_regulation_cfg[`GDC_CHOP_OFFTIME_SEL_HI:`GDC_CHOP_OFFTIME_SEL_LO];
  assign regulation_disable = current_regulation_cfg[`GDC_RDIS_BIT];
  assign reference_scale_sel = current_regulation_cfg[`GDC_SCL_HI:`GDC_SCL_LO];
  assign sample_hold_enable = current_regulation_cfg[`GDC_SH_BIT];
  assign amp_gain_sel = current_regulation_cfg[`GDC_GAIN_HI:`GDC_GAIN_LO];

  // ****************************************
  // Watchdog
  // ****************************************
  reg [`GDC_WD_CNT_W-1:0] wd_count;
  wire host_access = reg_wr || reg_rd;
  wire [`GDC_WD_CNT_W-1:0] wd_last = wd_limit(watchdog_timeout_sel) - 1'b1;
  // Counting restarts after expiry, so a host that stays silent is flagged again
  wire wd_expire = watchdog_enable_bit && !host_access && (wd_count >= wd_last);

  // Any host access restarts the count; disabling holds it at zero
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wd_count <= {`GDC_WD_CNT_W{1'b0}};
    end else if (!watchdog_enable_bit || host_access || wd_expire) begin
      wd_count <= {`GDC_WD_CNT_W{1'b0}};
    end else begin
      wd_count <= wd_count + 1'b1;
    end
  end

  // Expiry wins over a clear landing in the same cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watchdog_fault <= 1'b0;
    end else if (wd_expire) begin
      watchdog_fault <= 1'b1;
    end else if (fault_clear) begin
      watchdog_fault <= 1'b0;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  reg [7:0] next_rdata;

  // Unused bits of the lock register are not stored and read as zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `GDC_ADDR_LOCKCTL: next_rdata[`GDC_LOCK_HI:`GDC_LOCK_LO] = lock_field;
      `GDC_ADDR_GDWD: next_rdata = gate_drive_watchdog_ctrl;
      `GDC_ADDR_OCMON: next_rdata = overcurrent_monitor_ctrl;
      `GDC_ADDR_REGCFG: next_rdata = current_regulation_cfg;
      default: next_rdata = 8'h00;
    endcase
  end

  // Data holds between reads, so the host may pick it up late
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// [tb/gdc_cfg_sva.sv]
// Port checker for the configuration register bank
module gdc_cfg_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic fault_clear,
  input wire logic watchdog_fault,
  input wire logic config_locked,
  // Gate drive fields
  input wire logic watchdog_enable_bit,
  input wire logic [1:0] bridge_deadtime_sel,
  input wire logic [1:0] watchdog_timeout_sel,
  input wire logic [2:0] gate_current_strength
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [7:0] r3 = {bridge_deadtime_sel, watchdog_enable_bit, watchdog_timeout_sel,
    gate_current_strength};
  wire wr_ok = reg_wr && !config_locked;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_gdwd_write: assert property (wr_ok && reg_addr == 3 |=> r3 == $past(reg_wdata))
    else $error("gate drive write lost");
  a_gdwd_read: assert property (reg_rd && !reg_wr && reg_addr == 3 |=> reg_rdata == r3)
    else $error("gate drive readback wrong");
  a_lock_sets: assert property (reg_wr && reg_addr == 2 && reg_wdata[5:3] == 3'h6
    |=> config_locked) else $error("lock code ignored");
  a_unlock_clears: assert property (reg_wr && reg_addr == 2 && reg_wdata[5:3] == 3'h3
    |=> !config_locked) else $error("unlock code ignored");
  a_locked_hold: assert property (config_locked && reg_wr && reg_addr == 3 |=> $stable(r3))
    else $error("locked register changed");
  a_wd_idle: assert property (!watchdog_enable_bit |=> !$rose(watchdog_fault))
    else $error("fault while watchdog off");
  a_access_kick: assert property (reg_wr || reg_rd |=> !$rose(watchdog_fault))
    else $error("fault on host access");
  a_fault_sticky: assert property (watchdog_fault && !fault_clear |=> watchdog_fault)
    else $error("fault dropped without clear");
endmodule

// [tb/gdc_host.sv]
// Host model driving the register port at falling edges
module gdc_host (
  // Clock and read data
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  // Register port requests
  output logic reg_wr = 0,
  output logic reg_rd = 0,
  output logic [5:0] reg_addr = 0,
  output logic [7:0] reg_wdata = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys);
    // Stale data is inverted so nothing can lean on it
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd = 0;
    d = reg_rdata;
  endtask
endmodule

// [tb/gdc_config_regs_tb_top.sv]
// Top testbench for the configuration register bank
`include "gdc_consts.vh"
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t bad", $time); end
module gdc_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rstn = 0, fault_clear = 0, reg_wr, reg_rd, watchdog_fault, config_locked;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] bridge_deadtime_sel, watchdog_timeout_sel, chop_offtime_sel;
  logic [1:0] reference_scale_sel, amp_gain_sel;
  logic [2:0] gate_current_strength, drain_source_threshold;
  logic watchdog_enable_bit, sense_output_clamp, high2_monitor_off, low2_monitor_off;
  logic high1_monitor_off, low1_monitor_off, regulation_disable, sample_hold_enable;
  logic [7:0] pat [6] = '{8'hD5, 8'hA5, 8'hAE, 8'h0A, 8'h5A, 8'h51};
  int n_errors = 0, n_tests = 0, wd_n [4] = '{10, 20, 50, 100};
  wire [7:0] f [3:5];
  assign f[3] = {bridge_deadtime_sel, watchdog_enable_bit, watchdog_timeout_sel,
    gate_current_strength};
  assign f[4] = {sense_output_clamp, drain_source_threshold, high2_monitor_off,
    low2_monitor_off, high1_monitor_off, low1_monitor_off};
  assign f[5] = {chop_offtime_sel, regulation_disable, reference_scale_sel,
    sample_hold_enable, amp_gain_sel};
  always #50 clk_sys = ~clk_sys;
  gdc_host i_host (.*);
  // One count per ms keeps the longest timeout at 100 cycles
  gdc_config_regs #(.WD_SCALE_KHZ(1)) i_dut (.*);
  task tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rstn = 1;
    `CHK(f[3], 8'h07)
    `CHK(f[4], 8'h70)
    `CHK(f[5], 8'h01)
    i_host.rd(2, d);
    `CHK(d, 8'h18)
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      i_host.wr(3 + i % 3, pat[i]);
      `CHK(f[3 + i % 3], pat[i])
      i_host.rd(3 + i % 3, d);
      `CHK(d, pat[i])
    end
    i_host.wr(6'h3F, 8'hFF);
    `CHK({f[3], f[4], f[5]}, {pat[3], pat[4], pat[5]})
    i_host.rd(6'h3F, d);
    `CHK(d, 8'h00)
    $display("field test done");
    i_host.wr(2, 8'h30);
    `CHK(config_locked, 1'b1)
    i_host.wr(3, 8'hD5);
    `CHK(f[3], 8'h0A)
    i_host.wr(2, 8'h18);
    `CHK(config_locked, 1'b0)
    $display("lock test done");
    for (int c = 0; c < 4; c++) begin
      i_host.wr(3, {3'b001, c[1:0], 3'b000});
      repeat (wd_n[c] - 2) @(negedge clk_sys);
      `CHK(watchdog_fault, 1'b0)
      repeat (3) @(negedge clk_sys);
      `CHK(watchdog_fault, 1'b1)
      @(negedge clk_sys) fault_clear = 1;
      @(negedge clk_sys) fault_clear = 0;
      `CHK(watchdog_fault, 1'b0)
    end
    i_host.wr(3, 8'h00);
    repeat (120) @(negedge clk_sys);
    `CHK(watchdog_fault, 1'b0)
    $display("watchdog test done");
    // Reset in mid-run must restore the fields and drop the lock
    i_host.wr(3, 8'hD5);
    i_host.wr(2, 8'h30);
    `CHK(config_locked, 1'b1)
    @(negedge clk_sys) rstn = 0;
    @(negedge clk_sys) rstn = 1;
    `CHK(config_locked, 1'b0)
    `CHK({f[3], f[4], f[5]}, {8'h07, 8'h70, 8'h01})
    i_host.rd(2, d);
    `CHK(d, 8'h18)
    i_host.wr(4, 8'hA5);
    `CHK(f[4], 8'hA5)
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule
bind gdc_config_regs gdc_cfg_sva i_chk (.*);
